// ### hdl/scs_pkg.sv
// Shared constants and types of the serial command shift interface
package scs_pkg;

  // ********************************************************
  // Frame and timing
  // ********************************************************
  localparam int CMD_BITS       = 20;
  localparam int CNT_W          = 5;
  localparam int MCLK_PERIOD_NS = 10;
  localparam int FILT_NS        = 20;
  // Least time, so round up
  localparam int FILT_CYC       = (FILT_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int FILT_W         = 3;

  // ********************************************************
  // Field positions
  // ********************************************************
  localparam int SEL_HI   = 19;
  localparam int SEL_LO   = 18;
  localparam int SEL_SUB  = 17;
  localparam int FMT_HI   = 5;
  localparam int FMT_LO   = 4;

  // ********************************************************
  // Encodings and reset values
  // ********************************************************
  localparam logic [1:0]          SEL_DRIVE_CTRL = 2'h0;
  localparam logic [2:0]          TGT_CHOPPER    = 3'h4;
  localparam logic [2:0]          TGT_CURRENT    = 3'h5;
  localparam logic [2:0]          TGT_LOAD       = 3'h6;
  localparam logic [2:0]          TGT_DRV_CONF   = 3'h7;
  localparam logic [1:0]          FMT_STEP       = 2'h0;
  localparam logic [1:0]          FMT_LOAD       = 2'h1;
  localparam logic [1:0]          FMT_LOAD_CUR   = 2'h2;
  localparam logic [1:0]          FMT_DIAG       = 2'h3;
  localparam logic [1:0]          PAD_ZERO       = 2'h0;
  localparam logic [1:0]          PAD_ONE        = 2'h3;
  localparam logic [CMD_BITS-1:0] WORD_RST       = 20'h00000;
  localparam logic [CNT_W-1:0]    CNT_RST        = 5'h00;
  localparam logic [CNT_W-1:0]    CNT_FULL       = 5'h14;

  // ********************************************************
  // Types
  // ********************************************************
  typedef logic [CMD_BITS-1:0] scs_word_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_FRAME = 2'b01,
    ST_LATCH = 2'b11
  } scs_state_e;

  // diag[8] is the low-supply flag, diag[7:0] the short and temperature flags
  typedef struct packed {
    logic [9:0] mstep;
    logic [9:0] load;
    logic [4:0] cur;
    logic [8:0] diag;
    logic [7:0] flags;
  } scs_stat_s;

  typedef struct packed {
    scs_word_t drive_ctrl;
    scs_word_t chopper;
    scs_word_t current_ctl;
    scs_word_t load_detect;
    scs_word_t driver_configuration_register;
  } scs_cfg_s;

endpackage

// ### hdl/scs_sync_filt.sv
// Two-stage synchroniser followed by a glitch filter for one pin
`timescale 1ns/100ps
module scs_sync_filt #(
  parameter logic RST_VAL = 1'b1
) (
  // Clock and reset
  input  wire logic i_mclk,
  input  wire logic i_nrst,
  // Pin and clean level
  input  wire logic i_pin,
  output logic      o_level
);
  import scs_pkg::*;

  typedef struct packed {
    logic              meta;
    logic              sync;
    logic              level;
    logic [FILT_W-1:0] cnt;
  } scs_filt_s;

  localparam scs_filt_s FILT_RST = '{meta: RST_VAL, sync: RST_VAL, level: RST_VAL, cnt: '0};
  localparam logic [FILT_W-1:0] FILT_LAST = FILT_W'(FILT_CYC - 1);

  scs_filt_s s_q;
  scs_filt_s s_d;

  always_comb begin
    s_d      = s_q;
    s_d.meta = i_pin;
    s_d.sync = s_q.meta;
    // Level moves only once the pin has held FILT_CYC samples
    if (s_q.sync == s_q.level) begin
      s_d.cnt = '0;
    end else if (s_q.cnt == FILT_LAST) begin
      s_d.level = s_q.sync;
      s_d.cnt   = '0;
    end else begin
      s_d.cnt = s_q.cnt + FILT_W'(1);
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      s_q <= FILT_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_level = s_q.level;

endmodule

// ### hdl/scs_spi_cmd.sv
// Serial command port: 20-bit shift register, command latch and response select
//
// Operation
// - A low chip select opens a frame; bits are counted only while it is low.
// - Sample input on rising bus clock edges; change output after falling edges.
// - Words travel most significant bit first in both directions.
// - Extra bits reappear on the output 20 clocks later, for chaining.
// - Chip select rising copies the shift register into a new command only if the full flag (20 bits) is set.
// - With more than 20 bits, only the last 20 form the command.
// - Driver enable, and chip select in the system clock domain, ignore pulses shorter than 20 ns.
// - Each frame returns status values and bits on the serial output.
// - Bits 19, 18 and sometimes 17 pick one of five configuration registers.
// - The response layout follows the format select in the driver configuration.
`timescale 1ns/100ps
module scs_spi_cmd (
  // System clock and reset
  input  wire logic              i_mclk,
  input  wire logic              i_nrst,
  // Serial link
  input  wire logic              i_sclk,
  input  wire logic              i_chip_select_low,
  input  wire logic              i_sdi,
  output logic                   o_sdo,
  // Driver enable pin
  input  wire logic              i_driver_enable_low_input,
  output logic                   o_driver_enable_low,
  // Status from the motor core
  input  wire scs_pkg::scs_stat_s i_stat,
  // Configuration and command events
  output scs_pkg::scs_cfg_s      o_cfg,
  output logic                   o_cmd_stb,
  output logic [2:0]             o_cmd_tgt
);
  import scs_pkg::*;

  // ********************************************************
  // Bus clock domain
  // ********************************************************
  // Full flag is not cleared by chip select high, so the system side can still judge the frame
  typedef struct packed {
    scs_word_t sh;
    logic      full;
  } scs_pos_s;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } scs_cnt_s;

  typedef struct packed {
    logic sdo;
    logic started;
  } scs_neg_s;

  scs_pos_s  p_q;
  scs_pos_s  p_d;
  scs_cnt_s  c_q;
  scs_cnt_s  c_d;
  scs_neg_s  n_q;
  scs_neg_s  n_d;
  logic      frame_rst_n;
  scs_word_t resp_w;

  // Chip select high holds the frame counters cleared, so each frame starts fresh
  assign frame_rst_n = i_nrst & ~i_chip_select_low;

  always_comb begin
    p_d = p_q;
    c_d = c_q;
    if (c_q.cnt == CNT_RST) begin
      p_d.sh = {resp_w[CMD_BITS-2:0], i_sdi};
    end else begin
      p_d.sh = {p_q.sh[CMD_BITS-2:0], i_sdi};
    end
    if (c_q.cnt != CNT_FULL) begin
      c_d.cnt = c_q.cnt + CNT_W'(1);
    end
    p_d.full = (c_d.cnt == CNT_FULL);
  end

  // Shift word keeps its value across chip select high for the command copy
  always_ff @(posedge i_sclk or negedge i_nrst) begin
    if (!i_nrst) begin
      p_q <= '{sh: WORD_RST, full: 1'b0};
    end else begin
      p_q <= p_d;
    end
  end

  always_ff @(posedge i_sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      c_q <= '{cnt: CNT_RST};
    end else begin
      c_q <= c_d;
    end
  end

  always_comb begin
    n_d         = n_q;
    n_d.started = (c_q.cnt != CNT_RST);
    n_d.sdo     = p_q.sh[CMD_BITS-1];
  end

  always_ff @(negedge i_sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      n_q <= '{sdo: 1'b0, started: 1'b0};
    end else begin
      n_q <= n_d;
    end
  end

  // Before the first falling edge after a rising one, the response MSB is shown
  assign o_sdo = n_q.started ? n_q.sdo : resp_w[CMD_BITS-1];

  // ********************************************************
  // System clock domain
  // ********************************************************
  typedef struct packed {
    scs_state_e st;
    scs_cfg_s   cfg;
    scs_word_t  resp;
    logic       stb;
    logic [2:0] tgt;
  } scs_sys_s;

  scs_sys_s   s_q;
  scs_sys_s   s_d;
  logic       cs_level;
  logic       en_level;
  logic [2:0] sel;
  logic [1:0] fmt;
  scs_word_t  fmt_word;

  scs_sync_filt #(
    .RST_VAL (1'b1)
  ) u_cs_filt (
    .i_mclk  (i_mclk),
    .i_nrst  (i_nrst),
    .i_pin   (i_chip_select_low),
    .o_level (cs_level)
  );

  scs_sync_filt #(
    .RST_VAL (1'b1)
  ) u_en_filt (
    .i_mclk  (i_mclk),
    .i_nrst  (i_nrst),
    .i_pin   (i_driver_enable_low_input),
    .o_level (en_level)
  );

  assign sel = p_q.sh[SEL_HI:SEL_SUB];
  assign fmt = s_q.cfg.driver_configuration_register[FMT_HI:FMT_LO];

  always_comb begin
    case (fmt)
      FMT_STEP: begin
        fmt_word = {i_stat.mstep, PAD_ZERO, i_stat.flags};
      end
      FMT_LOAD: begin
        fmt_word = {i_stat.load, PAD_ZERO, i_stat.flags};
      end
      FMT_LOAD_CUR: begin
        fmt_word = {i_stat.load[9:5], i_stat.cur, PAD_ZERO, i_stat.flags};
      end
      default: begin
        fmt_word = {i_stat.diag[8], en_level, i_stat.diag[7:0], PAD_ONE, i_stat.flags};
      end
    endcase
  end

  always_comb begin
    s_d     = s_q;
    s_d.stb = 1'b0;
    case (s_q.st)
      ST_IDLE: begin
        // Response is frozen while the frame runs, so the link sees a stable word
        s_d.resp = fmt_word;
        if (!cs_level) begin
          s_d.st = ST_FRAME;
        end
      end
      ST_FRAME: begin
        if (cs_level) begin
          s_d.st = ST_LATCH;
        end
      end
      ST_LATCH: begin
        // Short frames are dropped; a full count means the last 20 bits are in place
        if (p_q.full) begin
          s_d.stb = 1'b1;
          s_d.tgt = sel;
          if (sel[2:1] == SEL_DRIVE_CTRL) begin
            s_d.cfg.drive_ctrl = p_q.sh;
          end else begin
            case (sel)
              TGT_CHOPPER: begin
                s_d.cfg.chopper = p_q.sh;
              end
              TGT_CURRENT: begin
                s_d.cfg.current_ctl = p_q.sh;
              end
              TGT_LOAD: begin
                s_d.cfg.load_detect = p_q.sh;
              end
              default: begin
                s_d.cfg.driver_configuration_register = p_q.sh;
              end
            endcase
          end
        end
        s_d.st = ST_IDLE;
      end
      default: begin
        s_d.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      s_q <= '{st: ST_IDLE, cfg: '0, resp: WORD_RST, stb: 1'b0, tgt: 3'h0};
    end else begin
      s_q <= s_d;
    end
  end

  // Read by the bus clock domain at a frame's first rising edge; its MSB drives o_sdo up to the falling edge that follows it, chip select high included
  assign resp_w              = s_q.resp;
  assign o_cfg               = s_q.cfg;
  assign o_cmd_stb           = s_q.stb;
  assign o_cmd_tgt           = s_q.tgt;
  assign o_driver_enable_low = en_level;

endmodule

// ### bench/scs_spi_cmd_assertions.sv
// Checker of the serial command port
`timescale 1ns/100ps
module scs_chk
  import scs_pkg::*;
(
  // Clock and reset
  input wire logic       i_mclk,
  input wire logic       i_nrst,
  // Pins
  input wire logic       i_sclk,
  input wire logic       i_chip_select_low,
  input wire logic       i_driver_enable_low_input,
  input wire logic       o_sdo,
  input wire logic       o_driver_enable_low,
  // Command side
  input wire scs_cfg_s   o_cfg,
  input wire logic       o_cmd_stb,
  input wire logic [2:0] o_cmd_tgt
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);

  a_stb_one_cycle: assert property (o_cmd_stb |=> !o_cmd_stb)
    else $error("strobe longer than one cycle");
  a_stb_when_idle: assert property (o_cmd_stb |-> i_chip_select_low && $past(i_chip_select_low, 3))
    else $error("strobe while selected");
  a_stb_after_sync: assert property ($rose(i_chip_select_low) |-> !o_cmd_stb [*3])
    else $error("strobe before synchroniser delay");
  a_cfg_on_stb: assert property ($changed(o_cfg) |-> o_cmd_stb)
    else $error("configuration moved without strobe");
  a_tgt_on_stb: assert property ($changed(o_cmd_tgt) |-> o_cmd_stb)
    else $error("target moved without strobe");
  a_conf_decode: assert property ($changed(o_cfg.driver_configuration_register) |-> o_cmd_tgt == TGT_DRV_CONF)
    else $error("driver configuration written by wrong select");
  a_enable_filter: assert property ($changed(o_driver_enable_low) |-> o_driver_enable_low == $past(i_driver_enable_low_input, 2))
    else $error("enable output follows no settled input");
  // Late start so the response load at frame open is not judged
  a_sdo_hold_high: assert property (!i_chip_select_low && !$past(i_chip_select_low, 5) && i_sclk && $past(i_sclk) |-> $stable(o_sdo))
    else $error("serial output moved while bus clock high");
endmodule

// ### bench/scs_master.sv
// Bus master model driving the serial command port
`timescale 1ns/100ps
module scs_master (
  // Serial link
  output logic      o_sclk,
  output logic      o_chip_select_low,
  output logic      o_sdi,
  input  wire logic i_sdo
);
  initial begin
    o_sclk = 1'b1;
    o_chip_select_low = 1'b1;
    o_sdi = 1'b0;
  end
  // Mode 3, 30 ns period, clock stands still between frames
  task automatic xfer(input int n, input logic [31:0] din, output logic [31:0] dout);
    dout = '0;
    o_chip_select_low = 1'b0;
    #45;
    for (int k = n - 1; k >= 0; k--) begin
      o_sclk = 1'b0;
      o_sdi = din[k];
      #15;
      o_sclk = 1'b1;
      dout = {dout[30:0], i_sdo};
      #15;
    end
    o_chip_select_low = 1'b1;
    // Released line must not keep its last value
    o_sdi = ~o_sdi;
    #100;
  endtask
endmodule

// ### bench/scs_spi_cmd_tb.sv
// Self-checking bench of the serial command port
`timescale 1ns/100ps
module scs_spi_cmd_tb;
  import scs_pkg::*;
  logic        mclk, nrst, sclk, chip_select_low, sdi, sdo, en_low_in, en_low, stb;
  logic [2:0]  tgt;
  logic [31:0] rsp;
  scs_stat_s   stat;
  scs_cfg_s    cfg;
  int          err_total, compares, stb_seen;

  scs_spi_cmd i_dut (.i_mclk(mclk), .i_nrst(nrst), .i_sclk(sclk), .i_chip_select_low(chip_select_low),
    .i_sdi(sdi), .o_sdo(sdo), .i_driver_enable_low_input(en_low_in), .o_driver_enable_low(en_low),
    .i_stat(stat), .o_cfg(cfg), .o_cmd_stb(stb), .o_cmd_tgt(tgt));
  scs_master i_mst (.o_sclk(sclk), .o_chip_select_low(chip_select_low), .o_sdi(sdi), .i_sdo(sdo));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) if (stb === 1'b1) stb_seen++;

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task print_verdict;
    if (err_total == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  function logic [19:0] exp_resp(input logic [1:0] f);
    case (f)
      FMT_STEP: exp_resp = {stat.mstep, PAD_ZERO, stat.flags};
      FMT_LOAD: exp_resp = {stat.load, PAD_ZERO, stat.flags};
      FMT_LOAD_CUR: exp_resp = {stat.load[9:5], stat.cur, PAD_ZERO, stat.flags};
      default: exp_resp = {stat.diag[8], en_low_in, stat.diag[7:0], PAD_ONE, stat.flags};
    endcase
  endfunction

  // Write one frame, then judge strobe, target and destination word
  task send(input int n, input logic [31:0] din, input int idx);
    int s;
    s = stb_seen;
    i_mst.xfer(n, din, rsp);
    chk(stb_seen - s, 1);
    chk(tgt, din[19:17]);
    chk(cfg[(4 - idx) * 20 +: 20], din[19:0]);
  endtask

  task t_formats;
    logic [19:0] w[4];
    w = '{20'h01234, 20'h8abcd, 20'ha5a5a, 20'hc3c3c};
    for (int f = 0; f < 4; f++) begin
      send(20, {12'h0, 8'he0, 6'h0, f[1:0], 4'h0}, 4);
      send(20, {12'h0, w[f]}, f);
      chk(rsp[19:0], exp_resp(f[1:0]));
    end
  endtask

  // Four extra leading bits come back after twenty clocks
  task t_chain;
    send(24, 32'h0098f00f, 1);
    chk(rsp[3:0], 4'h9);
    chk(rsp[23:4], exp_resp(FMT_DIAG));
  endtask

  task t_short;
    int s;
    s = stb_seen;
    i_mst.xfer(19, 32'h7ffff, rsp);
    chk(stb_seen - s, 0);
    chk(cfg.driver_configuration_register, {8'he0, 6'h0, FMT_DIAG, 4'h0});
  endtask

  task t_enable;
    int n;
    @(posedge mclk) en_low_in <= 1'b0;
    @(posedge mclk) en_low_in <= 1'b1;
    // A one-cycle pulse must never show, so each of the next 8 cycles is watched
    n = 0;
    repeat (8) begin
      @(negedge mclk);
      if (en_low !== 1'b1) n++;
    end
    chk(n, 0);
    @(posedge mclk) en_low_in <= 1'b0;
    n = 0;
    while (en_low !== 1'b0 && n < 10) begin
      @(negedge mclk);
      n++;
    end
    chk(en_low, 1'b0);
  endtask

  initial begin
    nrst = 1'b0;
    en_low_in = 1'b1;
    err_total = 0;
    compares = 0;
    stb_seen = 0;
    stat = {10'h2a5, 10'h1c3, 5'h16, 9'h15a, 8'hc9};
    repeat (6) @(posedge mclk);
    nrst <= 1'b1;
    repeat (6) @(negedge mclk);
    chk(|cfg, 1'b0);
    chk(tgt, 3'h0);
    chk(en_low, 1'b1);
    #3;
    t_formats;
    t_chain;
    t_short;
    t_enable;
    print_verdict;
  end
endmodule

bind scs_spi_cmd scs_chk i_chk (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_sclk(i_sclk),
  .i_chip_select_low(i_chip_select_low), .i_driver_enable_low_input(i_driver_enable_low_input),
  .o_sdo(o_sdo), .o_driver_enable_low(o_driver_enable_low), .o_cfg(o_cfg), .o_cmd_stb(o_cmd_stb),
  .o_cmd_tgt(o_cmd_tgt));
